// >>> core/ccg_pkg.sv
// Package: constants for the clock generator and wait controller
package ccg_pkg;
    // Master oscillator figures
    localparam int unsigned OSC_FREQ_MHZ  = 16;
    localparam int unsigned CPU_FREQ_MHZ  = 4;
    localparam int unsigned PER2_FREQ_MHZ = 2;
    localparam int unsigned PER1_FREQ_MHZ = 1;
    // Divider width and tap positions, derived from the ratios
    localparam int unsigned DIV_W      = 4;
    localparam int unsigned TAP_CPU    = $clog2(OSC_FREQ_MHZ / CPU_FREQ_MHZ) - 1;
    localparam int unsigned TAP_PER2   = $clog2(OSC_FREQ_MHZ / PER2_FREQ_MHZ) - 1;
    localparam int unsigned TAP_PER1   = $clog2(OSC_FREQ_MHZ / PER1_FREQ_MHZ) - 1;
    localparam logic [3:0]  DIV_RESET  = 4'h0;
    // Ready timeout
    localparam int unsigned TMO_CYCLES = 16;
    localparam int unsigned TMO_W      = 5;
    localparam logic [4:0]  TMO_LIMIT  = 5'(TMO_CYCLES);
    localparam logic [4:0]  TMO_RESET  = 5'h00;
    // Status codes that stop the timeout counter (state lines 3..1)
    localparam logic [2:0]  ST_INTERNAL_OP = 3'h0;
    localparam logic [2:0]  ST_REFRESH     = 3'h1;
    // Single-step sequencer
    typedef enum logic [1:0] {
        CCG_STEP_HALT = 2'b00,
        CCG_STEP_OPEN = 2'b01,
        CCG_STEP_DONE = 2'b10
    } ccg_step_t;
endpackage : ccg_pkg

// >>> core/ccg_status_decode.sv
// Module: decode of the processor status lines for the timeout gate
`timescale 1ns/10ps
`default_nettype none
module ccg_status_decode #(
    parameter logic [2:0] INTERNAL_CODE = ccg_pkg::ST_INTERNAL_OP,
    parameter logic [2:0] REFRESH_CODE  = ccg_pkg::ST_REFRESH
) (
    // Status lines
    input  wire logic cpu_state_line_1,
    input  wire logic cpu_state_line_2,
    input  wire logic cpu_state_line_3,
    // Decoded gate
    output logic      counter_blocked
);
    wire logic [2:0] code;
    wire logic       is_internal;
    wire logic       is_refresh;

    assign code            = {cpu_state_line_3, cpu_state_line_2, cpu_state_line_1};
    assign is_internal     = (code == INTERNAL_CODE);
    assign is_refresh      = (code == REFRESH_CODE);
    assign counter_blocked = is_internal | is_refresh;
endmodule : ccg_status_decode
`default_nettype wire

// >>> core/ccg_clock_wait.sv
// Module: clock dividers, clock outputs and processor wait control
//
// Overview of operation
// - One 16 MHz oscillator times every clock
// - Divide oscillator by four for processor clock
// - Buffered undivided oscillator on separate output
// - Synchronous 2 MHz and 1 MHz peripheral clocks
// - Logic-level copy of processor clock
// - Common clear puts all dividers in phase
// - Wait from run/halt, single-step and ready
// - Halt holds active-low wait asserted
// - Timeout caps peripheral wait at 16 cycles
// - Guarded expiry drives flag high, and wait high unless halt holds it
// - Status decode stops counter in internal/refresh
`timescale 1ns/10ps
`default_nettype none
module ccg_clock_wait (
    // Clock and reset
    input  wire logic clk,
    input  wire logic reset,
    // Oscillator
    input  wire logic osc_in,
    // Divider control
    input  wire logic div_clear,
    // Clock outputs
    output logic      mem_clk,
    output logic      cpu_clk,
    output logic      cpu_clk_ttl,
    output logic      per_clk_2m,
    output logic      per_clk_1m,
    // Wait control inputs
    input  wire logic run_halt_n,
    input  wire logic single_step,
    input  wire logic ready_n,
    input  wire logic bus_cycle_end,
    input  wire logic timeout_enable,
    // Status lines
    input  wire logic cpu_state_line_1,
    input  wire logic cpu_state_line_2,
    input  wire logic cpu_state_line_3,
    // Wait outputs
    output logic      wait_n,
    output logic      timeout
);
    // ========================================================
    // Dividers
    // ========================================================
    // The divider counts on clk, which stands for the 16 MHz oscillator
    // edge; osc_in is only buffered onward.
    logic [ccg_pkg::DIV_W-1:0] div_count;
    wire  logic [ccg_pkg::DIV_W-1:0] next_div_count;

    wire  logic                      div_zero;

    assign next_div_count = div_count + 4'h1;
    // Clear is synchronous, so it cannot glitch, but it can cut a derived clock's current phase short
    assign div_zero       = reset | div_clear;

    // Limitation: clk must run at the oscillator rate for the
    // derived frequencies to hold
    always_ff @(posedge clk) begin
        if (div_zero) begin
            div_count <= ccg_pkg::DIV_RESET;
        end else begin
            div_count <= next_div_count;
        end
    end

    // ========================================================
    // Clock outputs
    // ========================================================
    // Re-timed by one flip-flop: a cycle late, but free of glitches
    always_ff @(posedge clk) begin
        if (reset) begin
            mem_clk <= 1'b0;
        end else begin
            mem_clk <= osc_in;
        end
    end

    // All taps of one counter, so every derived clock stays in phase
    // Both processor copies share one bit, so they cannot skew
    assign cpu_clk     = div_count[ccg_pkg::TAP_CPU];
    assign cpu_clk_ttl = div_count[ccg_pkg::TAP_CPU];
    assign per_clk_2m  = div_count[ccg_pkg::TAP_PER2];
    assign per_clk_1m  = div_count[ccg_pkg::TAP_PER1];

    // ========================================================
    // Status decode
    // ========================================================
    wire  logic                      counter_blocked;

    // Codes live in the decoder, so another processor only changes
    // two parameters; status lines are taken as settled
    ccg_status_decode #(
        .INTERNAL_CODE (ccg_pkg::ST_INTERNAL_OP),
        .REFRESH_CODE  (ccg_pkg::ST_REFRESH)
    ) u_decode (
        .cpu_state_line_1 (cpu_state_line_1),
        .cpu_state_line_2 (cpu_state_line_2),
        .cpu_state_line_3 (cpu_state_line_3),
        .counter_blocked  (counter_blocked)
    );

    // ========================================================
    // Ready timeout
    // ========================================================
    logic [ccg_pkg::TMO_W-1:0]       tmo_count;
    wire  logic                      ready_req;
    wire  logic                      tmo_clear;
    wire  logic                      tmo_hit;
    wire  logic [ccg_pkg::TMO_W-1:0] next_tmo_count;

    assign ready_req      = ~ready_n;
    // Any break in the request starts the count afresh
    assign tmo_clear      = reset | ~ready_req | ~timeout_enable | counter_blocked;
    assign tmo_hit        = (tmo_count == ccg_pkg::TMO_LIMIT);
    // Five bits hold the limit itself, so saturation needs no wrap guard
    assign next_tmo_count = tmo_hit ? tmo_count : tmo_count + 5'h01;

    // Counter restarts with each new request and saturates at the limit
    always_ff @(posedge clk) begin
        if (tmo_clear) begin
            tmo_count <= ccg_pkg::TMO_RESET;
        end else begin
            tmo_count <= next_tmo_count;
        end
    end

    // Flag rises on the same edge as the wait release
    always_ff @(posedge clk) begin
        if (reset) begin
            timeout <= 1'b0;
        end else begin
            timeout <= tmo_hit;
        end
    end

    // ========================================================
    // Run/halt and single step
    // ========================================================
    ccg_pkg::ccg_step_t step_state;
    ccg_pkg::ccg_step_t next_step_state;

    logic               step_last;
    wire  logic         step_rise;
    wire  logic         step_idle;

    assign step_rise = single_step & ~step_last;
    assign step_idle = reset | run_halt_n;

    // A step asked for while one is open or closing is dropped
    always_comb begin
        next_step_state = step_state;
        unique case (step_state)
            ccg_pkg::CCG_STEP_HALT: begin
                if (step_rise) begin
                    next_step_state = ccg_pkg::CCG_STEP_OPEN;
                end
            end
            ccg_pkg::CCG_STEP_OPEN: begin
                if (bus_cycle_end) begin
                    next_step_state = ccg_pkg::CCG_STEP_DONE;
                end
            end
            ccg_pkg::CCG_STEP_DONE: begin
                next_step_state = ccg_pkg::CCG_STEP_HALT;
            end
            default: begin
                next_step_state = ccg_pkg::CCG_STEP_HALT;
            end
        endcase
    end

    // Running forces the sequencer back to its halted entry
    always_ff @(posedge clk) begin
        if (step_idle) begin
            step_state <= ccg_pkg::CCG_STEP_HALT;
        end else begin
            step_state <= next_step_state;
        end
    end

    // Tracked while running too, so a step pin held high across
    // the change to halt is not taken as a new step
    always_ff @(posedge clk) begin
        if (reset) begin
            step_last <= 1'b0;
        end else begin
            step_last <= single_step;
        end
    end

    // ========================================================
    // Wait output
    // ========================================================
    wire logic halt_wait;
    wire logic ready_wait;
    wire logic next_wait_n;

    assign halt_wait   = ~run_halt_n & (step_state != ccg_pkg::CCG_STEP_OPEN);
    // Released on the hit itself so wait and flag rise together;
    // the timeout frees a stuck peripheral but never overrides halt
    assign ready_wait  = ready_req & ~tmo_hit;
    assign next_wait_n = ~(halt_wait | ready_wait);

    // Registered so the processor never sees a decode glitch
    always_ff @(posedge clk) begin
        if (reset) begin
            wait_n <= 1'b1;
        end else begin
            wait_n <= next_wait_n;
        end
    end
endmodule : ccg_clock_wait
`default_nettype wire

// >>> verif/ccg_clock_wait_properties.sv
// Checker: port-level properties of the clock and wait block
`timescale 1ns/10ps
`default_nettype none
module ccg_clock_wait_properties (
    // Clock, reset and oscillator
    input wire logic clk, reset, osc_in, div_clear,
    // Clock outputs
    input wire logic mem_clk, cpu_clk, cpu_clk_ttl, per_clk_2m, per_clk_1m,
    // Wait control, status and wait outputs
    input wire logic run_halt_n, single_step, ready_n, timeout_enable,
    input wire logic cpu_state_line_1, cpu_state_line_2, cpu_state_line_3, wait_n, timeout
);
    logic       gate;
    logic [4:0] run_len;
    default clocking @(posedge clk); endclocking
    default disable iff (reset);
    assign gate = !ready_n && timeout_enable && !({cpu_state_line_3, cpu_state_line_2,
        cpu_state_line_1} inside {ccg_pkg::ST_INTERNAL_OP, ccg_pkg::ST_REFRESH});
    // Saturates so a long request never wraps back to a small count
    always_ff @(posedge clk) begin
        if (reset || !gate) run_len <= 5'h00;
        else if (run_len != 5'h1F) run_len <= run_len + 5'h01;
    end
    a_ttl_copy: assert property (cpu_clk_ttl == cpu_clk)
        else $error("ttl clock differs");
    a_cpu_quarter: assert property ($changed(cpu_clk) && !div_clear |=> $stable(cpu_clk))
        else $error("cpu clock half period wrong");
    a_per_phase: assert property ($rose(per_clk_1m) |-> $fell(per_clk_2m) && $fell(cpu_clk))
        else $error("peripheral clocks out of phase");
    a_mem_copy: assert property (!$past(reset) |-> mem_clk == $past(osc_in))
        else $error("memory clock not a copy");
    a_reset_values: assert property ($past(reset) |-> wait_n && !timeout && !cpu_clk)
        else $error("reset values wrong");
    a_halt_wait: assert property ($fell(run_halt_n) |=> !wait_n)
        else $error("halt did not assert wait");
    a_step_opens: assert property (!run_halt_n && ready_n && !wait_n && $rose(single_step)
        |-> ##[1:2] wait_n) else $error("step did not release wait");
    a_ready_wait: assert property (run_halt_n && !ready_n && $past(ready_n) |=> !wait_n)
        else $error("ready request gave no wait");
    a_expiry_count: assert property (run_len == 5'h10 && gate && run_halt_n
        |-> !timeout ##1 (timeout && wait_n)) else $error("expiry not at 16");
    a_gate_off: assert property (!gate [*2] |=> !timeout)
        else $error("expiry while counter stopped");
endmodule : ccg_clock_wait_properties
bind ccg_clock_wait ccg_clock_wait_properties i_props (.*);
`default_nettype wire

// >>> verif/ccg_cpu_model.sv
// Processor model: ends one bus transaction after a set count of free cycles
`timescale 1ns/10ps
`default_nettype none
module ccg_cpu_model (
    // Clock and wait input
    input  wire logic       clk,
    input  wire logic       wait_n,
    input  wire logic [3:0] hold_cycles,
    // Transaction end
    output logic            bus_cycle_end
);
    logic [3:0] cnt = 4'h0;
    initial bus_cycle_end = 1'b0;
    // Wait low restarts the transaction's count of free cycles from zero
    always @(posedge clk) begin
        bus_cycle_end <= #1 wait_n && (cnt == hold_cycles);
        cnt <= #1 (wait_n && cnt != hold_cycles) ? cnt + 4'h1 : 4'h0;
    end
endmodule : ccg_cpu_model
`default_nettype wire

// >>> verif/tb_top.sv
// Testbench: dividers, halt and step, ready wait and timeout
`timescale 1ns/10ps
`default_nettype none
module tb_top;
    logic clk, reset, osc_in, div_clear, mem_clk, cpu_clk, cpu_clk_ttl, per_clk_2m, per_clk_1m;
    logic run_halt_n, single_step, ready_n, bus_cycle_end, timeout_enable, wait_n, timeout;
    logic cpu_state_line_1, cpu_state_line_2, cpu_state_line_3;
    logic [3:0] hold;
    int fails, checked, k, ends;
    ccg_clock_wait i_dut (.*);
    ccg_cpu_model i_cpu (.clk(clk), .wait_n(wait_n), .hold_cycles(hold), .bus_cycle_end(bus_cycle_end));
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : tick
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        checked++;
        if (seen !== exp) begin
            fails++;
            $display("ERROR %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask : chk
    task automatic finish_test;
        if (fails == 0 && checked > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : finish_test
    // Bounded wait for a wait level, counting transaction ends meanwhile
    task automatic await(input logic lvl);
        k = 0;
        while (wait_n !== lvl) begin
            ends += int'(bus_cycle_end === 1'b1);
            tick(1);
            k++;
            if (k > 40) begin
                fails++;
                finish_test;
            end
        end
    endtask : await
    initial begin
        {reset, osc_in, div_clear, single_step, timeout_enable} = 5'h10;
        {run_halt_n, ready_n, hold} = 6'h32;
        {cpu_state_line_3, cpu_state_line_2, cpu_state_line_1} = 3'h0;
        {fails, checked, ends} = '0;
        tick(20);
        reset = 1'b0;
        chk({wait_n, timeout, cpu_clk, mem_clk}, 8'h08);
        // Let the divider run off zero so the clear has work to do
        tick(3);
        div_clear = 1'b1;
        tick(1);
        div_clear = 1'b0;
        for (int i = 0; i < 16; i++) begin
            chk({per_clk_1m, per_clk_2m, cpu_clk, cpu_clk_ttl, mem_clk}, {i[3:1], i[1], osc_in});
            osc_in = ~osc_in;
            tick(1);
        end
        run_halt_n = 1'b0;
        tick(2);
        chk(wait_n, 1'b0);
        // Prompt and slow transactions, stepped back to back
        for (int h = 2; h < 8; h += 3) begin
            {hold, ends, single_step} = {h[3:0], 32'h0, 1'b1};
            tick(1);
            single_step = 1'b0;
            await(1'b1);
            await(1'b0);
            chk(8'(ends), 8'h01);
        end
        run_halt_n = 1'b1;
        ready_n = 1'b0;
        tick(20);
        chk({wait_n, timeout}, 2'h0);
        {ready_n, timeout_enable} = 2'h3;
        tick(2);
        chk(wait_n, 1'b1);
        // Codes 0 and 1 stop the count, code 2 lets it run to expiry
        for (int s = 0; s < 3; s++) begin
            {cpu_state_line_3, cpu_state_line_2, cpu_state_line_1, ready_n, k} = {s[2:0], 33'h0};
            while (timeout !== 1'b1 && k < 30) begin
                tick(1);
                k++;
            end
            chk(8'(k), (s == 2) ? 8'h11 : 8'h1E);
            chk({wait_n, timeout}, (s == 2) ? 2'h3 : 2'h0);
            ready_n = 1'b1;
            tick(2);
        end
        // Reset in mid-run drops a standing expiry; wait stays released
        ready_n = 1'b0;
        tick(18);
        chk({wait_n, timeout}, 2'h3);
        reset = 1'b1;
        tick(1);
        chk({wait_n, timeout, cpu_clk}, 3'h4);
        {reset, ready_n} = 2'h1;
        tick(2);
        chk({wait_n, timeout}, 2'h2);
        finish_test;
    end
endmodule : tb_top
`default_nettype wire
